// *** rtl/fwdg_pkg.sv ***
// constants, types and register map of the free-running key watchdog
package fwdg_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] KEY_COMMAND_OFS   = 8'h00;
  localparam logic [7:0] PRESCALE_OFS      = 8'h04;
  localparam logic [7:0] RELOAD_OFS        = 8'h08;
  localparam logic [7:0] UPDATE_STATUS_OFS = 8'h0c;
  localparam logic [7:0] DEBUG_CTRL_OFS    = 8'h10;
  localparam logic [7:0] WATCH_STATUS_OFS  = 8'h14;

  // ==========================================================================
  // key command codes
  localparam logic [15:0] KEY_UNLOCK = 16'h5555;
  localparam logic [15:0] KEY_START  = 16'hcccc;
  localparam logic [15:0] KEY_RELOAD = 16'haaaa;

  // ==========================================================================
  // field positions and widths
  localparam int KEY_W        = 16;
  localparam int PSEL_W       = 3;
  localparam int RELOAD_W     = 12;
  localparam int PDIV_W       = 8;
  localparam int STAT_PVU_BIT = 0;
  localparam int STAT_RVU_BIT = 1;
  localparam int DBG_FRZ_BIT  = 0;
  localparam int WST_RUN_BIT  = 16;
  localparam int WST_UNL_BIT  = 17;

  // ==========================================================================
  // reset values and timing counts
  localparam logic [PSEL_W-1:0]   PSEL_RST     = 3'h0;
  localparam logic [RELOAD_W-1:0] RELOAD_RST   = 12'hfff;
  localparam logic [PSEL_W-1:0]   PSEL_MAX     = 3'h6;
  localparam logic [1:0]          UPD_EDGES    = 2'h2;  // osc edges to carry an update across
  localparam logic [1:0]          STRAP_CYCLES = 2'h3;  // sync depth before the strap is read
  localparam logic [31:0]         INVALID_RD   = 32'h00000000;
  localparam logic [1:0]          RESP_OKAY    = 2'h0;
  localparam logic [1:0]          RESP_SLVERR  = 2'h2;

  // ==========================================================================
  // watchdog states, one-hot
  typedef enum logic [2:0] {
    FWDG_IDLE  = 3'b001,
    FWDG_RUN   = 3'b010,
    FWDG_FIRED = 3'b100
  } fwdg_state_t;

  // update progress carried as one group
  typedef struct packed {
    logic       busy;
    logic [1:0] edges;
  } fwdg_upd_t;

endpackage

// *** rtl/fwdg_top.sv ***
// free-running key watchdog with an AXI4-Lite register slave
//
// How it works
// R1 - prescaler then twelve-bit down-counter on ticks
// R2 - start key enables counting, never stops
// R3 - counter at zero raises system reset
// R4 - reload key loads reload value any time; here only while running, ignored when idle
// R5 - prescale and reload writable only after unlock
// R6 - any other key relocks those registers
// R7 - option strap starts watchdog at power-on
// R8 - update busy bit set while crossing
// R9 - freeze bit stops counting during debug halt
// R10 - select codes divide 4 to 256, 111=256
// R11 - prescale busy set, reads return invalid
// R12 - sixteen-bit write-only key selects command
// R13 - software waits for busy clear first
// R14 - /4 at 32 kHz: 0.125 to 512 ms
// R15 - counts from its own low-speed oscillator
// R16 - twelve-bit reload, resets to all ones
// R17 - status bits: reload bit1, prescale bit0
// R18 - start loads counter and clears prescaler
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module fwdg_top
  import fwdg_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [7:0]  ARADDR,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  input  wire logic        LOW_SPEED_OSC,
  input  wire logic        HW_WATCHDOG_OPT,
  input  wire logic        DEBUG_HALTED,
  output logic             SYS_RESET_REQ
);

  // ==========================================================================
  // helper functions

  // divider minus one for a select code
  function automatic logic [PDIV_W-1:0] div_limit(input logic [PSEL_W-1:0] sel);
    logic [PSEL_W-1:0] s;
    s = (sel > PSEL_MAX) ? PSEL_MAX : sel;
    div_limit = PDIV_W'((9'h004 << s) - 9'h001);
  endfunction

  // merge a write word into an old word by byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    strb_merge = r;
  endfunction

  // ==========================================================================
  // declarations
  logic                aw_full_q, w_full_q;
  logic [7:0]          aw_addr_q;
  logic [31:0]         w_data_q;
  logic [3:0]          w_strb_q;
  logic                awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]          bresp_q, rresp_q;
  logic [31:0]         rdata_q;
  logic                osc_s1_q, osc_s2_q, osc_s3_q, osc_f_q;
  logic                hlt_s1_q, hlt_s2_q, hlt_s3_q, hlt_f_q;
  logic                opt_s1_q, opt_s2_q, opt_s3_q;
  logic [1:0]          strap_cnt_q;
  logic                strap_done_q;
  logic                unlock_q;
  logic                freeze_q;
  logic [PSEL_W-1:0]   psel_sw_q, psel_act_q;
  logic [RELOAD_W-1:0] rld_sw_q, rld_act_q;
  fwdg_upd_t           pupd_q, rupd_q;
  logic [PDIV_W-1:0]   pdiv_q;
  logic [RELOAD_W-1:0] cnt_q;
  fwdg_state_t         state_q, state_d;
  logic                sysrst_q;

  // ==========================================================================
  // bus decode
  wire         wr_go    = aw_full_q && w_full_q && !bvalid_q;
  wire  [31:0] wr_word  = strb_merge(32'h00000000, w_data_q, w_strb_q);
  wire         wr_key   = wr_go && (aw_addr_q == KEY_COMMAND_OFS);
  wire         wr_pre   = wr_go && (aw_addr_q == PRESCALE_OFS);
  wire         wr_rld   = wr_go && (aw_addr_q == RELOAD_OFS);
  wire         wr_dbg   = wr_go && (aw_addr_q == DEBUG_CTRL_OFS);
  wire         wr_map   = wr_key || wr_pre || wr_rld || wr_dbg
                          || (aw_addr_q == UPDATE_STATUS_OFS) || (aw_addr_q == WATCH_STATUS_OFS);
  wire  [15:0] key_val  = wr_word[KEY_W-1:0];                       // [R12]
  wire         cmd_unl  = wr_key && (key_val == KEY_UNLOCK);
  wire         cmd_start = wr_key && (key_val == KEY_START);
  wire         cmd_rld  = wr_key && (key_val == KEY_RELOAD);
  wire         pre_ok   = wr_pre && unlock_q;                       // [R5]
  wire         rld_ok   = wr_rld && unlock_q;                       // [R5]
  wire         rd_go    = ARVALID && arready_q;

  // read data selection
  logic [31:0] rd_word;
  logic        rd_map;
  always_comb begin
    rd_word = 32'h00000000;
    rd_map  = 1'b1;
    case (ARADDR)
      KEY_COMMAND_OFS:   rd_word = 32'h00000000;                    // [R12]
      PRESCALE_OFS:      rd_word = pupd_q.busy ? INVALID_RD : {29'h0, psel_sw_q};      // [R11]
      RELOAD_OFS:        rd_word = rupd_q.busy ? INVALID_RD : {20'h0, rld_sw_q};       // [R16]
      UPDATE_STATUS_OFS: begin
        rd_word[STAT_RVU_BIT] = rupd_q.busy;                        // [R17]
        rd_word[STAT_PVU_BIT] = pupd_q.busy;                        // [R17]
      end
      DEBUG_CTRL_OFS:    rd_word[DBG_FRZ_BIT] = freeze_q;
      WATCH_STATUS_OFS:  begin
        rd_word[RELOAD_W-1:0] = cnt_q;
        rd_word[WST_RUN_BIT]  = (state_q == FWDG_RUN);
        rd_word[WST_UNL_BIT]  = unlock_q;
      end
      default:           rd_map = 1'b0;
    endcase
  end

  // ==========================================================================
  // write address and data capture, taken in either order
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_full_q <= 1'b0;
      awready_q <= 1'b1;
      aw_addr_q <= 8'h00;
    end else if (AWVALID && awready_q) begin
      aw_full_q <= 1'b1;
      awready_q <= 1'b0;
      aw_addr_q <= AWADDR;
    end else if (bvalid_q && BREADY) begin
      aw_full_q <= 1'b0;
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      w_full_q <= 1'b0;
      wready_q <= 1'b1;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (WVALID && wready_q) begin
      w_full_q <= 1'b1;
      wready_q <= 1'b0;
      w_data_q <= WDATA;
      w_strb_q <= WSTRB;
    end else if (bvalid_q && BREADY) begin
      w_full_q <= 1'b0;
      wready_q <= 1'b1;
    end
  end

  // write response, unmapped offsets answer with an error
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_map ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // read channel, one read at a time
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end else if (rd_go) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && RREADY) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // ==========================================================================
  // pin synchronisers, a change counts once stages two and three agree
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      {osc_s1_q, osc_s2_q, osc_s3_q, osc_f_q} <= 4'h0;
      {hlt_s1_q, hlt_s2_q, hlt_s3_q, hlt_f_q} <= 4'h0;
      {opt_s1_q, opt_s2_q, opt_s3_q}          <= 3'h0;
    end else begin
      {osc_s1_q, osc_s2_q, osc_s3_q} <= {LOW_SPEED_OSC, osc_s1_q, osc_s2_q};
      {hlt_s1_q, hlt_s2_q, hlt_s3_q} <= {DEBUG_HALTED, hlt_s1_q, hlt_s2_q};
      {opt_s1_q, opt_s2_q, opt_s3_q} <= {HW_WATCHDOG_OPT, opt_s1_q, opt_s2_q};
      if (osc_s2_q == osc_s3_q) begin
        osc_f_q <= osc_s3_q;
      end
      if (hlt_s2_q == hlt_s3_q) begin
        hlt_f_q <= hlt_s3_q;
      end
    end
  end

  // oscillator rising edge drives all watchdog timing
  wire osc_edge = (osc_s2_q == osc_s3_q) && osc_s3_q && !osc_f_q;   // [R15]
  wire frozen   = freeze_q && hlt_f_q;                              // [R9]
  wire pre_tick = osc_edge && !frozen && (pdiv_q == div_limit(psel_act_q));  // [R10]
  wire strap_go = !strap_done_q && (strap_cnt_q == STRAP_CYCLES) && opt_s2_q && opt_s3_q;

  // strap sampled once after the synchroniser has filled
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
    end else if (strap_cnt_q != STRAP_CYCLES) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end else begin
      strap_done_q <= 1'b1;
    end
  end

  // ==========================================================================
  // unlock flag and debug control
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      unlock_q <= 1'b0;
      freeze_q <= 1'b0;
    end else begin
      if (wr_key) begin
        unlock_q <= cmd_unl;                                        // [R5] [R6]
      end
      if (wr_dbg) begin
        freeze_q <= wr_word[DBG_FRZ_BIT];                           // [R9]
      end
    end
  end

  // software copies and their carry into the counting logic
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      psel_sw_q  <= PSEL_RST;
      psel_act_q <= PSEL_RST;
      pupd_q     <= '0;
    end else if (pre_ok) begin
      psel_sw_q <= wr_word[PSEL_W-1:0];
      pupd_q    <= '{busy: 1'b1, edges: 2'h0};                      // [R8] [R11]
    end else if (pupd_q.busy && osc_edge) begin
      if (pupd_q.edges == UPD_EDGES - 2'h1) begin
        psel_act_q <= psel_sw_q;
        pupd_q     <= '0;                                           // [R17]
      end else begin
        pupd_q.edges <= pupd_q.edges + 2'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rld_sw_q  <= RELOAD_RST;                                      // [R16]
      rld_act_q <= RELOAD_RST;
      rupd_q    <= '0;
    end else if (rld_ok) begin
      rld_sw_q <= wr_word[RELOAD_W-1:0];
      rupd_q   <= '{busy: 1'b1, edges: 2'h0};                       // [R8]
    end else if (rupd_q.busy && osc_edge) begin
      if (rupd_q.edges == UPD_EDGES - 2'h1) begin
        rld_act_q <= rld_sw_q;
        rupd_q    <= '0;                                            // [R17]
      end else begin
        rupd_q.edges <= rupd_q.edges + 2'h1;
      end
    end
  end

  // ==========================================================================
  // watchdog state: idle until started, running cannot be left by software
  always_comb begin
    state_d = state_q;
    case (state_q)
      FWDG_IDLE:  if (cmd_start || strap_go) state_d = FWDG_RUN;  // [R2] [R7]
      FWDG_RUN:   if (pre_tick && cnt_q == '0 && !cmd_rld) state_d = FWDG_FIRED;  // [R3]
      FWDG_FIRED: state_d = FWDG_FIRED;
      default:    state_d = FWDG_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q  <= FWDG_IDLE;
      sysrst_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      sysrst_q <= sysrst_q || (state_d == FWDG_FIRED);              // [R3]
    end
  end

  // prescaler and down-counter
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pdiv_q <= '0;
      cnt_q  <= RELOAD_RST;
    end else if (state_q == FWDG_IDLE) begin
      if (cmd_start || strap_go) begin
        pdiv_q <= '0;                                               // [R18]
        cnt_q  <= rld_act_q;                                        // [R18]
      end
    end else if (state_q == FWDG_RUN) begin
      if (osc_edge && !frozen) begin
        pdiv_q <= pre_tick ? '0 : pdiv_q + 1'b1;                    // [R1]
      end
      if (cmd_rld) begin
        cnt_q <= rld_act_q;                                         // [R4]
      end else if (pre_tick && cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;                                      // [R1] [R14]
      end
    end
  end

  // ==========================================================================
  // outputs
  assign AWREADY       = awready_q;
  assign WREADY        = wready_q;
  assign BVALID        = bvalid_q;
  assign BRESP         = bresp_q;
  assign ARREADY       = arready_q;
  assign RVALID        = rvalid_q;
  assign RDATA         = rdata_q;
  assign RRESP         = rresp_q;
  assign SYS_RESET_REQ = sysrst_q;

endmodule

// *** dv/fwdg_checker.sv ***
// assertion checker for the key watchdog register slave and reset output
`timescale 1ns/1ps
module fwdg_checker
  import fwdg_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        ARST_N,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic [7:0]  AWADDR,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic [1:0]  BRESP,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [7:0]  ARADDR,
  input wire logic        RVALID,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  input wire logic        LOW_SPEED_OSC,
  input wire logic        SYS_RESET_REQ
);
  // ==========================================================================
  // handshake decode
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  wire rd_take = ARVALID && ARREADY;
  wire wr_take = AWVALID && AWREADY && WVALID && WREADY;

  // ==========================================================================
  // assertions
  a_reset_sticky: assert property (SYS_RESET_REQ |=> SYS_RESET_REQ [*3])
    else $error("system reset dropped while armed");
  a_fire_on_osc: assert property ($rose(SYS_RESET_REQ) |-> LOW_SPEED_OSC)
    else $error("system reset not launched by an oscillator edge");
  a_key_reads_zero: assert property (rd_take && ARADDR == KEY_COMMAND_OFS |=> RVALID && RDATA == 32'h0)
    else $error("key register did not read as zero");
  a_prescale_width: assert property (rd_take && ARADDR == PRESCALE_OFS |=> RVALID && RDATA[31:3] == 29'h0)
    else $error("prescale read has bits above the select field");
  a_reload_width: assert property (rd_take && ARADDR == RELOAD_OFS |=> RVALID && RDATA[31:12] == 20'h0)
    else $error("reload read has bits above the twelve-bit field");
  a_status_width: assert property (rd_take && ARADDR == UPDATE_STATUS_OFS |=> RDATA[31:2] == 30'h0)
    else $error("status read has bits above the two busy flags");
  a_rd_unmapped: assert property (rd_take && ARADDR > WATCH_STATUS_OFS |=> RRESP == RESP_SLVERR && RDATA == 32'h0)
    else $error("unmapped read not refused");
  a_wr_unmapped: assert property (wr_take && AWADDR > WATCH_STATUS_OFS |-> ##2 BVALID && BRESP == RESP_SLVERR)
    else $error("unmapped write not refused");

  // ==========================================================================
  // coverage of the main scenarios
  c_fired: cover property ($rose(SYS_RESET_REQ));
  c_wr_err: cover property (BVALID && BRESP == RESP_SLVERR);
  c_status_rd: cover property (rd_take && ARADDR == UPDATE_STATUS_OFS);
endmodule

bind fwdg_top fwdg_checker fwdg_checker_inst (
  .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
  .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BRESP(BRESP), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RDATA(RDATA), .RRESP(RRESP),
  .LOW_SPEED_OSC(LOW_SPEED_OSC), .SYS_RESET_REQ(SYS_RESET_REQ)
);

// *** dv/tb_top.sv ***
// self-checking bench for the key watchdog
`timescale 1ns/1ps
module tb_top
  import fwdg_pkg::*;
;
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [1:0]  pre;
    logic [1:0]  resp;
    logic [31:0] mask;
    logic [31:0] exp;
  } fwdg_row_t;

  // ==========================================================================
  // stimulus and observed signals
  logic        CLK_SYS = 0, ARST_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic        LOW_SPEED_OSC = 0, HW_WATCHDOG_OPT = 0, DEBUG_HALTED = 0;
  logic [7:0]  AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0;
  logic [3:0]  WSTRB = 0;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, SYS_RESET_REQ;
  logic [1:0]  BRESP, RRESP, rs;
  logic [31:0] RDATA, rd;
  int          miscompares = 0, tests_run = 0, cyc = 0, n;

  // register table: write/read, offset, data, osc edges first, response, mask, expected
  fwdg_row_t rows[22] = '{
    '{0, 8'h00, 0, 0, 0, 32'hffffffff, 0}, '{0, 8'h04, 0, 0, 0, 32'hffffffff, 0},
    '{0, 8'h08, 0, 0, 0, 32'hffffffff, 32'hfff}, '{0, 8'h0c, 0, 0, 0, 32'hffffffff, 0},
    '{0, 8'h14, 0, 0, 0, 32'h30000, 0}, '{0, 8'h18, 0, 0, 2, 32'hffffffff, 0},
    '{1, 8'h18, 1, 0, 2, 0, 0}, '{1, 8'h04, 5, 0, 0, 0, 0},
    '{0, 8'h04, 0, 0, 0, 32'hffffffff, 0}, '{1, 8'h00, 32'h5555, 0, 0, 0, 0},
    '{0, 8'h14, 0, 0, 0, 32'h30000, 32'h20000}, '{1, 8'h00, 32'h1234, 0, 0, 0, 0},
    '{1, 8'h08, 7, 0, 0, 0, 0}, '{0, 8'h08, 0, 0, 0, 32'hffffffff, 32'hfff},
    '{1, 8'h00, 32'h5555, 0, 0, 0, 0}, '{1, 8'h04, 3, 0, 0, 0, 0},
    '{1, 8'h08, 9, 0, 0, 0, 0}, '{0, 8'h0c, 0, 0, 0, 32'hffffffff, 3},
    '{0, 8'h04, 0, 0, 0, 32'hffffffff, 0}, '{0, 8'h0c, 0, 2, 0, 32'hffffffff, 0},
    '{0, 8'h04, 0, 0, 0, 32'hffffffff, 3}, '{0, 8'h08, 0, 0, 0, 32'hffffffff, 9}};

  fwdg_top fwdg_top_inst (
    .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY),
    .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID),
    .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP), .LOW_SPEED_OSC(LOW_SPEED_OSC),
    .HW_WATCHDOG_OPT(HW_WATCHDOG_OPT), .DEBUG_HALTED(DEBUG_HALTED), .SYS_RESET_REQ(SYS_RESET_REQ));

  // ==========================================================================
  // clock and hang guard
  always #5 CLK_SYS = ~CLK_SYS;

  // a run far beyond the expected length counts as a mismatch
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc > 60000) begin
      miscompares++;
      end_sim();
    end
  end

  // ==========================================================================
  // compare, bus and pin tasks
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge CLK_SYS);
    AWVALID <= 1;
    AWADDR <= a;
    WVALID <= 1;
    WDATA <= d;
    WSTRB <= 4'hf;
    BREADY <= 1;
    while (!(aw && w)) begin
      @(posedge CLK_SYS);
      if (AWREADY === 1'b1) begin
        aw = 1;
        AWVALID <= 0;
      end
      if (WREADY === 1'b1) begin
        w = 1;
        WVALID <= 0;
      end
    end
    while (BVALID !== 1'b1) @(posedge CLK_SYS);
    r = BRESP;
    BREADY <= 0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge CLK_SYS);
    ARVALID <= 1;
    ARADDR <= a;
    RREADY <= 1;
    do @(posedge CLK_SYS); while (ARREADY !== 1'b1);
    ARVALID <= 0;
    do @(posedge CLK_SYS); while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
    RREADY <= 0;
  endtask

  // slow oscillator periods of twenty system cycles
  task automatic osc(input int k);
    repeat (k) begin
      @(posedge CLK_SYS);
      LOW_SPEED_OSC <= 1;
      repeat (10) @(posedge CLK_SYS);
      LOW_SPEED_OSC <= 0;
      repeat (9) @(posedge CLK_SYS);
    end
  endtask

  task automatic do_reset(input logic opt);
    @(posedge CLK_SYS);
    ARST_N <= 0;
    HW_WATCHDOG_OPT <= opt;
    DEBUG_HALTED <= 0;
    repeat (4) @(posedge CLK_SYS);
    ARST_N <= 1;
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    do_reset(0);
    foreach (rows[i]) begin
      osc(rows[i].pre);
      if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, rs);
      else axi_rd(rows[i].a, rd, rs);
      chk_word("response", {30'h0, rows[i].resp}, {30'h0, rs});
      if (!rows[i].wr) chk_word("read data", rows[i].exp, rd & rows[i].mask);
    end
    $display("test register table done");
    do_reset(1);
    repeat (8) @(posedge CLK_SYS);
    axi_rd(WATCH_STATUS_OFS, rd, rs);
    chk_word("strap start", 32'h00010fff, rd & 32'h00030fff);
    $display("test strap start done");
    for (int s = 0; s < 8; s++) begin
      do_reset(0);
      axi_wr(KEY_COMMAND_OFS, {16'h0, KEY_UNLOCK}, rs);
      axi_wr(PRESCALE_OFS, 32'(s), rs);
      axi_wr(RELOAD_OFS, 32'h0, rs);
      osc(2);
      axi_wr(KEY_COMMAND_OFS, {16'h0, KEY_START}, rs);
      n = 0;
      while (SYS_RESET_REQ !== 1'b1 && n < 300) begin
        osc(1);
        n++;
      end
      chk_word("edges to reset", 32'h4 << ((s > 6) ? 6 : s), 32'(n));
    end
    $display("test divider codes done");
    do_reset(0);
    axi_wr(KEY_COMMAND_OFS, {16'h0, KEY_UNLOCK}, rs);
    axi_wr(RELOAD_OFS, 32'h2, rs);
    osc(2);
    axi_wr(KEY_COMMAND_OFS, {16'h0, KEY_START}, rs);
    osc(4);
    axi_wr(KEY_COMMAND_OFS, 32'h0, rs);
    axi_wr(KEY_COMMAND_OFS, {16'h0, KEY_RELOAD}, rs);
    DEBUG_HALTED <= 1;
    axi_wr(DEBUG_CTRL_OFS, 32'h1, rs);
    osc(12);
    chk_bit("frozen reset", 1'b0, SYS_RESET_REQ);
    DEBUG_HALTED <= 0;
    axi_rd(WATCH_STATUS_OFS, rd, rs);
    chk_word("frozen count", 32'h00010002, rd & 32'h00010fff);
    osc(11);
    chk_bit("reset early", 1'b0, SYS_RESET_REQ);
    osc(1);
    chk_bit("reset on zero", 1'b1, SYS_RESET_REQ);
    $display("test reload and freeze done");
    end_sim();
  end
endmodule
